// File: hw/asts_serial_unit.sv
/*
 * Full-duplex asynchronous serial transmitter and receiver.
 * Assumes the prescaled base clock is sys_clk_i, inputs synchronous,
 * and mode bits changed only with both enables clear.
 */
module asts_serial_unit (
    // Clock and reset
    input  wire logic                            sys_clk_i,
    input  wire logic                            reset_n_i,
    // Mode and enables
    input  wire logic                            unit_power_on_i,
    input  wire logic                            tx_enable_bit_i,
    input  wire logic                            rx_enable_bit_i,
    input  wire logic [1:0]                      parity_mode_i,
    input  wire logic                            char_len8_i,
    input  wire logic                            stop_two_i,
    input  wire logic [asts_pkg::CNT_W-1:0]      baud_divisor_i,
    // Transmit side
    input  wire logic                            tx_write_i,
    input  wire logic [asts_pkg::DATA_W-1:0]     tx_data_i,
    output logic                                 tx_done_irq_o,
    // Receive side
    input  wire logic                            rx_buffer_read_i,
    input  wire logic                            err_status_read_i,
    output logic [asts_pkg::DATA_W-1:0]          rx_buffer_o,
    output logic [asts_pkg::ERR_W-1:0]           rx_error_status_o,
    output logic                                 rx_done_irq_o,
    output logic                                 rx_error_irq_o,
    // Serial line
    input  wire logic                            serial_in_pin_i,
    output logic                                 serial_out_pin_o
);
    asts_pkg::asts_state_s s;
    asts_pkg::asts_state_s next_s;

    // ------------------------------------------------------------
    // Baud counters, one per direction
    // ------------------------------------------------------------
    asts_baud_if tx_baud ();
    asts_baud_if rx_baud ();

    // Counters restart whenever their path goes idle
    assign tx_baud.run     = (s.tx_left != '0);
    assign tx_baud.divisor = baud_divisor_i;
    assign rx_baud.run     = (s.rx_st != asts_pkg::ASTS_RX_IDLE);
    assign rx_baud.divisor = baud_divisor_i;

    asts_baud_counter u_tx_baud (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .bus       (tx_baud.cnt)
    );

    asts_baud_counter u_rx_baud (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .bus       (rx_baud.cnt)
    );

    // ------------------------------------------------------------
    // Helper decodes
    // ------------------------------------------------------------
    logic tx_on;
    logic rx_on;
    logic rx_in;
    logic tx_go;
    logic has_par;

    // Line reads high while unpowered, so no false start
    assign tx_on   = unit_power_on_i & tx_enable_bit_i;
    assign rx_on   = unit_power_on_i & rx_enable_bit_i;
    assign rx_in   = serial_in_pin_i | ~unit_power_on_i;
    assign tx_go   = tx_on & tx_write_i & (s.tx_left == '0);
    assign has_par = (parity_mode_i != asts_pkg::PAR_NONE);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [asts_pkg::FRAME_W-1:0] fr;
        logic [asts_pkg::RXSH_W-1:0]  sh;
        logic [asts_pkg::IDX_W-1:0]   dl;
        logic [asts_pkg::IDX_W-1:0]   last;
        logic [asts_pkg::DATA_W-1:0]  d;
        logic [asts_pkg::ERR_W-1:0]   ne;
        logic                         pb;
        logic                         ones;
        fr   = '1;
        sh   = s.rx_shift;
        dl   = asts_pkg::asts_dlen(char_len8_i);
        last = dl + (has_par ? asts_pkg::ONE : '0);
        d    = '0;
        ne   = '0;
        pb   = asts_pkg::SPACE;
        ones = asts_pkg::SPACE;
        next_s = s;
        next_s.tx_done  = 1'h0;
        next_s.rx_done  = 1'h0;
        next_s.rx_error = 1'h0;
        next_s.rx_prev  = rx_in;

        // Transmit: frame built whole at the write
        if (tx_go) begin
            ones = asts_pkg::asts_ones(tx_data_i, char_len8_i);
            case (parity_mode_i)
                asts_pkg::PAR_EVEN: pb = ones;
                asts_pkg::PAR_ODD:  pb = ~ones;
                default:            pb = asts_pkg::SPACE;
            endcase
            fr[0] = asts_pkg::SPACE;
            for (int i = 0; i < asts_pkg::DATA_W; i++) begin
                if (i < int'(dl)) begin
                    fr[i + 1] = tx_data_i[i];
                end
            end
            // No parity slot at all in no-parity mode
            if (has_par) begin
                fr[dl + asts_pkg::ONE] = pb;
            end
            next_s.tx_frame   = fr;
            next_s.serial_out = asts_pkg::SPACE;
            next_s.tx_half    = 1'h0;
            // Start, data, parity, then one or two stops
            next_s.tx_left = last + asts_pkg::ONE
                           + (stop_two_i ? asts_pkg::TWO : asts_pkg::ONE);
        end else if (s.tx_left != '0 && tx_baud.tick) begin
            // Two counter periods make one bit
            next_s.tx_half = ~s.tx_half;
            if (s.tx_half) begin
                next_s.tx_frame = {asts_pkg::MARK,
                                   s.tx_frame[asts_pkg::FRAME_W-1:1]};
                next_s.serial_out = s.tx_frame[1];
                next_s.tx_left = s.tx_left - asts_pkg::ONE;
                // Done the moment the last stop bit ends
                if (s.tx_left == asts_pkg::ONE) begin
                    next_s.tx_done    = 1'h1;
                    next_s.serial_out = asts_pkg::MARK;
                end
            end
        end

        // Receive: qualify the start bit at mid-bit
        case (s.rx_st)
            asts_pkg::ASTS_RX_IDLE: begin
                if (rx_on && s.rx_prev && !rx_in) begin
                    next_s.rx_st = asts_pkg::ASTS_RX_START;
                end
            end
            asts_pkg::ASTS_RX_START: begin
                if (rx_baud.tick) begin
                    next_s.rx_half  = 1'h0;
                    next_s.rx_idx   = '0;
                    next_s.rx_shift = '0;
                    next_s.rx_st = rx_in ? asts_pkg::ASTS_RX_IDLE
                                         : asts_pkg::ASTS_RX_BITS;
                end
            end
            asts_pkg::ASTS_RX_BITS: begin
                if (rx_baud.tick) begin
                    next_s.rx_half = ~s.rx_half;
                    if (s.rx_half) begin
                        // Shift each bit in at its centre
                        sh[s.rx_idx]    = rx_in;
                        next_s.rx_shift = sh;
                        next_s.rx_idx   = s.rx_idx + asts_pkg::ONE;
                        // Only the first stop bit is looked at
                        if (s.rx_idx == last) begin
                            d = sh[asts_pkg::DATA_W-1:0];
                            if (!char_len8_i) begin
                                d[asts_pkg::DATA_W-1] = asts_pkg::SPACE;
                            end
                            ones = asts_pkg::asts_ones(d, char_len8_i);
                            pb   = sh[dl];
                            // Parity checked, reception not aborted
                            case (parity_mode_i)
                                asts_pkg::PAR_EVEN:
                                    ne[asts_pkg::ERR_PE] = ones ^ pb;
                                asts_pkg::PAR_ODD:
                                    ne[asts_pkg::ERR_PE] = ~ones ^ pb;
                                default:
                                    ne[asts_pkg::ERR_PE] = 1'h0;
                            endcase
                            ne[asts_pkg::ERR_FE]  = ~rx_in;
                            ne[asts_pkg::ERR_OVE] = s.rx_full;
                            // Unread buffer keeps the older byte
                            if (!s.rx_full) begin
                                next_s.rx_buf = d;
                            end
                            next_s.rx_done  = 1'h1;
                            next_s.rx_error = |ne;
                            next_s.rx_st    = asts_pkg::ASTS_RX_IDLE;
                        end
                    end
                end
            end
            default: next_s.rx_st = asts_pkg::ASTS_RX_IDLE;
        endcase

        // Reads clear; a new error, or a byte stored into an empty buffer, in the same cycle wins
        next_s.err = (err_status_read_i ? '0 : s.err) | ne;
        if (rx_buffer_read_i) begin
            next_s.rx_full = 1'h0;
        end
        if (next_s.rx_done && !s.rx_full) begin
            next_s.rx_full = 1'h1;
        end

        // Enables reset their own path
        if (!tx_on) begin
            next_s.tx_frame   = '1;
            next_s.tx_left    = '0;
            next_s.tx_half    = 1'h0;
            next_s.tx_done    = 1'h0;
            next_s.serial_out = asts_pkg::MARK;
        end
        if (!rx_on) begin
            next_s.rx_st    = asts_pkg::ASTS_RX_IDLE;
            next_s.rx_half  = 1'h0;
            next_s.rx_idx   = '0;
            next_s.rx_done  = 1'h0;
            next_s.rx_error = 1'h0;
        end
        // Power off also clears data and status
        if (!unit_power_on_i) begin
            next_s.err      = '0;
            next_s.rx_buf   = '0;
            next_s.rx_full  = 1'h0;
            next_s.rx_shift = '0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s <= asts_pkg::STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state flops
    assign serial_out_pin_o  = s.serial_out;
    assign tx_done_irq_o     = s.tx_done;
    assign rx_done_irq_o     = s.rx_done;
    assign rx_error_irq_o    = s.rx_error;
    assign rx_buffer_o       = s.rx_buf;
    assign rx_error_status_o = s.err;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    chk_idle_mark: assert property (
        s.tx_left == '0 |-> serial_out_pin_o)
        else $error("idle line not at mark");
    chk_tx_start: assert property (
        tx_go |=> !serial_out_pin_o && tx_baud.run)
        else $error("no start bit after write");
    chk_done_pulse: assert property (
        tx_done_irq_o |-> $past(s.tx_left) == asts_pkg::ONE
            ##1 !tx_done_irq_o)
        else $error("transmit done not a single pulse");
    chk_tx_disable: assert property (
        !tx_on |=> s.tx_left == '0 && serial_out_pin_o)
        else $error("transmit path not reset");
    chk_power_clear: assert property (
        !unit_power_on_i |=> rx_error_status_o == '0
            && rx_buffer_o == '0)
        else $error("power off left data or status");
    chk_status_read: assert property (
        err_status_read_i && !next_s.rx_done |=> rx_error_status_o == '0)
        else $error("status read did not clear");
    chk_overrun_keep: assert property (
        rx_done_irq_o && rx_error_status_o[asts_pkg::ERR_OVE]
            |-> $stable(rx_buffer_o))
        else $error("overrun overwrote buffer");
    chk_no_parity_err: assert property (
        !parity_mode_i[1] && $stable(parity_mode_i)
            |-> !$rose(rx_error_status_o[asts_pkg::ERR_PE]))
        else $error("parity error without checked parity");
    chk_err_irq: assert property (
        rx_error_irq_o |-> rx_done_irq_o && rx_error_status_o != '0)
        else $error("error pulse without status");
    chk_false_start: assert property (
        s.rx_st == asts_pkg::ASTS_RX_START && rx_baud.tick && rx_in
            |=> s.rx_st == asts_pkg::ASTS_RX_IDLE)
        else $error("high sample accepted as start");

    cov_tx_frame: cover property (tx_go ##[1:1000] tx_done_irq_o);
    cov_rx_frame: cover property (rx_done_irq_o && !rx_error_irq_o);
    cov_rx_error: cover property (rx_error_irq_o);
    cov_overrun:  cover property (
        rx_done_irq_o && rx_error_status_o[asts_pkg::ERR_OVE]);
endmodule

// File: hw/asts_pkg.sv
/*
 * Shared constants, types and helpers for the asynchronous serial unit.
 * Assumes one 100 MHz base clock and configuration bits held steady
 * while the enables are set.
 */
// What this block does
// - Start bit, then 7/8 data bits LSB first
// - Even, odd, zero or no parity; 1/2 stops
// - Even parity: total ones even, else error
// - Odd parity: total ones odd, else error
// - Zero parity sends 0, never checked
// - No parity: no bit, no error
// - Power on drives serial output high
// - Parity and stops follow; done after last stop
// - Transmitter idles until next byte written
// - Falling edge, count, low sample means start
// - Shift bits in, on stop raise done, buffer
// - Overrun leaves receive buffer unchanged
// - Parity error flagged after frame completes
// - Receiver checks exactly one stop bit
// - Enables reset paths; power clears data, status
// - Reading error status clears all flags
// - Missing stop bit raises framing error
// - Bit period is two counter periods
package asts_pkg;

    // ------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------
    localparam int unsigned DATA_W  = 8;
    localparam int unsigned CNT_W   = 5;
    localparam int unsigned FRAME_W = 12;
    localparam int unsigned IDX_W   = 4;
    localparam int unsigned RXSH_W  = 10;
    localparam int unsigned ERR_W   = 3;
    localparam int unsigned ERR_PE  = 0;
    localparam int unsigned ERR_FE  = 1;
    localparam int unsigned ERR_OVE = 2;

    // ------------------------------------------------------------
    // Parity modes, frame pieces, timing
    // ------------------------------------------------------------
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD  = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;
    localparam logic [IDX_W-1:0] LEN7 = 4'h7;
    localparam logic [IDX_W-1:0] LEN8 = 4'h8;
    localparam logic [IDX_W-1:0] ONE  = 4'h1;
    localparam logic [IDX_W-1:0] TWO  = 4'h2;
    localparam logic MARK  = 1'h1;
    localparam logic SPACE = 1'h0;
    // Least wait from transmit enable to first write, in ns
    localparam int unsigned CLK_NS       = 10;
    localparam int unsigned TX_WAIT_NS   = 20;
    localparam int unsigned TX_WAIT_CYC  = (TX_WAIT_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        ASTS_RX_IDLE,
        ASTS_RX_START,
        ASTS_RX_BITS
    } asts_rx_e;

    typedef struct packed {
        logic                serial_out;
        logic [FRAME_W-1:0]  tx_frame;
        logic [IDX_W-1:0]    tx_left;
        logic                tx_half;
        logic                tx_done;
        asts_rx_e            rx_st;
        logic                rx_prev;
        logic                rx_half;
        logic [IDX_W-1:0]    rx_idx;
        logic [RXSH_W-1:0]   rx_shift;
        logic [DATA_W-1:0]   rx_buf;
        logic                rx_full;
        logic [ERR_W-1:0]    err;
        logic                rx_done;
        logic                rx_error;
    } asts_state_s;

    localparam asts_state_s STATE_RST = '{serial_out: MARK,
        rx_prev: MARK, rx_st: ASTS_RX_IDLE, default: '0};

    // Ones parity of the character, bit 7 masked in 7-bit mode
    function automatic logic asts_ones(input logic [DATA_W-1:0] d,
                                       input logic len8);
        asts_ones = ^(len8 ? d : {SPACE, d[DATA_W-2:0]});
    endfunction

    // Character bits in a frame
    function automatic logic [IDX_W-1:0] asts_dlen(input logic len8);
        asts_dlen = len8 ? LEN8 : LEN7;
    endfunction

endpackage

// File: hw/asts_baud_if.sv
/*
 * Link between the serial core and one 5-bit baud counter.
 * Assumes both ends share sys_clk_i.
 */
interface asts_baud_if;
    logic                          run;
    logic [asts_pkg::CNT_W-1:0]    divisor;
    logic                          tick;

    // Core drives run and divisor, counter answers with tick
    modport ctl (output run, output divisor, input tick);
    modport cnt (input run, input divisor, output tick);
endinterface

// File: hw/asts_baud_counter.sv
/*
 * Programmable 5-bit counter: one tick pulse every divisor cycles.
 * Assumes divisor of 8 or more; run low holds it cleared.
 */
module asts_baud_counter (
    // Clock and reset
    input  wire logic  sys_clk_i,
    input  wire logic  reset_n_i,
    // Counter link
    asts_baud_if.cnt   bus
);
    typedef struct packed {
        logic [asts_pkg::CNT_W-1:0] count;
        logic                       tick;
    } asts_baud_s;

    asts_baud_s s;
    asts_baud_s next_s;

    // Count while running, wrap at divisor minus one
    always_comb begin
        next_s = s;
        next_s.tick = 1'h0;
        if (!bus.run) begin
            next_s.count = '0;
        end else if (s.count == bus.divisor - 5'h01) begin
            next_s.count = '0;
            next_s.tick = 1'h1;
        end else begin
            next_s.count = s.count + 5'h01;
        end
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bus.tick = s.tick;
endmodule

// File: verification/asts_peer.sv
/*
 * Far-side serial peer: sends frames into the unit, captures its frames.
 * Assumes bit period 2*k_i clocks and a line idling at mark level.
 */
module asts_peer (
    // Clock
    input  wire logic         sys_clk_i,
    // Line setup
    input  wire logic [4:0]   k_i,
    input  wire logic [3:0]   nbits_i,
    // Serial line
    input  wire logic         line_i,
    output logic              line_o,
    // Captured frame
    output logic              got_valid_o,
    output logic [11:0]       got_frame_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        prev;
    logic [11:0] f;
    initial begin
        line_o = 1'b1;
        got_valid_o = 1'b0;
        got_frame_o = '0;
        prev = 1'b1;
    end
    // Bits leave LSB first; line returns to mark after the last stop
    task automatic send(input logic [11:0] fr, input int n);
        @(posedge sys_clk_i);
        #1;
        for (int i = 0; i < n; i++) begin
            line_o = fr[i];
            repeat (2 * k_i) @(posedge sys_clk_i);
            #1;
        end
        line_o = 1'b1;
    endtask
    // Low pulse too short to pass the start-bit resample
    task automatic glitch(input int c);
        @(posedge sys_clk_i);
        #1;
        line_o = 1'b0;
        repeat (c) @(posedge sys_clk_i);
        #1;
        line_o = 1'b1;
    endtask
    // Sample on the falling clock edge, mid bit, away from line updates
    always begin
        @(negedge sys_clk_i);
        if (prev === 1'b1 && line_i === 1'b0) begin
            f = '0;
            repeat (k_i - 1) @(negedge sys_clk_i);
            for (int i = 0; i < nbits_i; i++) begin
                f[i] = line_i;
                if (i < nbits_i - 1) repeat (2 * k_i) @(negedge sys_clk_i);
            end
            got_frame_o = f;
            got_valid_o = 1'b1;
            @(negedge sys_clk_i);
            got_valid_o = 1'b0;
        end
        prev = line_i;
    end
endmodule

// File: verification/testbench.sv
/*
 * Self-checking bench for the serial unit, with a line peer.
 * Assumes the unit's ports as declared and a 100 MHz clock.
 */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------
    // Signals and bookkeeping
    // ----------------------------------------------------------
    localparam int LIMIT = 60000;
    localparam int DLY   = 1;
    logic sys_clk_i = 1'b0, reset_n = 1'b0, pwr = 1'b0;
    logic tx_en = 1'b0, rx_en = 1'b0, l8 = 1'b1, s2 = 1'b0;
    logic tx_wr = 1'b0, buf_rd = 1'b0, st_rd = 1'b0;
    logic [1:0]  pm = 2'h0;
    logic [4:0]  k = 5'h08;
    logic [7:0]  tx_d = 8'h00, rx_buf, a;
    logic [2:0]  rx_st;
    logic        tx_done, rx_done, rx_err, ser_out, ser_in, pv;
    logic [11:0] pf, f, tq[$];
    logic [10:0] rq[$], rx_exp;
    logic [3:0]  n_tx = 4'hb;
    logic [31:0] seed = 32'h822a_9d50;
    int err_total = 0, cmp_count = 0, cyc = 0, n;

    always #5 sys_clk_i = ~sys_clk_i;

    asts_serial_unit asts_serial_unit_i (.sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n), .unit_power_on_i(pwr), .tx_enable_bit_i(tx_en),
        .rx_enable_bit_i(rx_en), .parity_mode_i(pm), .char_len8_i(l8),
        .stop_two_i(s2), .baud_divisor_i(k), .tx_write_i(tx_wr),
        .tx_data_i(tx_d), .tx_done_irq_o(tx_done), .rx_buffer_read_i(buf_rd),
        .err_status_read_i(st_rd), .rx_buffer_o(rx_buf),
        .rx_error_status_o(rx_st), .rx_done_irq_o(rx_done),
        .rx_error_irq_o(rx_err), .serial_in_pin_i(ser_in),
        .serial_out_pin_o(ser_out));
    asts_peer asts_peer_i (.sys_clk_i(sys_clk_i), .k_i(k), .nbits_i(n_tx),
        .line_i(ser_out), .line_o(ser_in), .got_valid_o(pv),
        .got_frame_o(pf));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic note(input logic bad, input string m);
        cmp_count++;
        if (bad) begin
            err_total++;
            $display("ERROR t=%0t %s", $time, m);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Frame image, start in bit 0; only the first stop can be spoiled
    function automatic int make_frame(input logic [7:0] d, input logic flip,
        input logic bad, output logic [11:0] fr);
        int m;
        logic p;
        fr = '0;
        m = 1;
        for (int i = 0; i < (l8 ? 8 : 7); i++) fr[m++] = d[i];
        p = ^{l8 & d[7], d[6:0]};
        if (pm == asts_pkg::PAR_ODD) p = ~p;
        if (pm == asts_pkg::PAR_ZERO) p = 1'b0;
        if (pm != asts_pkg::PAR_NONE) fr[m++] = p ^ flip;
        fr[m++] = ~bad;
        if (s2) fr[m++] = 1'b1;
        return m;
    endfunction
    // Mode bits change only with both enables clear
    task automatic set_cfg(input logic [2:0] c);
        @(posedge sys_clk_i) #DLY;
        tx_en = 1'b0;
        rx_en = 1'b0;
        @(posedge sys_clk_i) #DLY;
        {l8, pm} = c;
        s2 = c[0] ^ c[2];
        k = 5'h08 + {2'h0, rnd() & 32'h7};
        @(posedge sys_clk_i) #DLY;
        tx_en = 1'b1;
        rx_en = 1'b1;
        repeat (asts_pkg::TX_WAIT_CYC) @(posedge sys_clk_i);
    endtask
    task automatic tx_byte(input logic [7:0] d);
        logic [11:0] fr;
        int i;
        n_tx = make_frame(d, 1'b0, 1'b0, fr);
        tq.push_back(fr);
        @(posedge sys_clk_i) #DLY;
        tx_wr = 1'b1;
        tx_d = d;
        @(posedge sys_clk_i) #DLY;
        tx_wr = 1'b0;
        for (i = 0; i < 900 && tx_done !== 1'b1; i++) begin
            @(posedge sys_clk_i) #DLY;
        end
        note(i >= 900, "no transmit done");
        note(ser_out !== 1'b1, "line not mark at done");
    endtask
    task automatic rx_frame(input logic [7:0] d, input logic flip,
        input logic bad);
        logic [11:0] fr;
        int m;
        m = make_frame(d, flip, bad, fr);
        rq.push_back({1'b0, bad, flip & pm[1], l8 & d[7], d[6:0]});
        asts_peer_i.send(fr, m);
    endtask
    // Status read first, then buffer, then confirm flags cleared
    task automatic sw_read();
        @(posedge sys_clk_i) #DLY;
        st_rd = 1'b1;
        @(posedge sys_clk_i) #DLY;
        st_rd = 1'b0;
        buf_rd = 1'b1;
        @(posedge sys_clk_i) #DLY;
        buf_rd = 1'b0;
        @(posedge sys_clk_i) #DLY;
        note(rx_st !== 3'h0, "status not cleared");
    endtask

    // ----------------------------------------------------------
    // Result watchers and hang guard
    // ----------------------------------------------------------
    // Frames seen on the transmit line, in write order
    always @(posedge sys_clk_i) if (pv === 1'b1) begin
        f = tq.pop_front();
        note(pf !== f, "transmit frame");
    end
    // Received results, looked at mid cycle once outputs have settled
    always @(negedge sys_clk_i) if (rx_done === 1'b1) begin
        if (rq.size() == 0) note(1'b1, "unexpected frame");
        else begin
            rx_exp = rq.pop_front();
            note(rx_buf !== rx_exp[7:0], "receive data");
            note(rx_st !== rx_exp[10:8], "receive status");
            note(rx_err !== (rx_exp[10:8] != 3'h0), "error irq");
        end
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            $display("ERROR t=%0t run too long", $time);
            test_done();
        end
    end

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk_i) #DLY;
        reset_n = 1'b1;
        @(posedge sys_clk_i) #DLY;
        pwr = 1'b1;
        repeat (2) @(posedge sys_clk_i) #DLY;
        note(ser_out !== 1'b1, "idle level");
        // Every parity mode with both lengths and stop counts
        for (int c = 0; c < 8; c++) begin
            set_cfg(c[2:0]);
            tx_byte(rnd());
            tx_byte(rnd());
            rx_frame(rnd(), 1'b0, 1'b0);
            sw_read();
            rx_frame(rnd(), 1'b1, 1'b0);
            sw_read();
            rx_frame(rnd(), 1'b0, 1'b1);
            sw_read();
            $display("config %0d done", c);
        end
        for (int i = 0; i < 30; i++) begin
            @(posedge sys_clk_i) #DLY;
            note(ser_out !== 1'b1, "line left mark");
        end
        // Second frame before the buffer is read
        set_cfg(3'h3);
        a = rnd();
        rx_frame(a, 1'b0, 1'b0);
        n = make_frame(rnd(), 1'b0, 1'b0, f);
        rq.push_back({3'h4, l8 & a[7], a[6:0]});
        asts_peer_i.send(f, n);
        $display("overrun done");
        @(posedge sys_clk_i) #DLY;
        pwr = 1'b0;
        repeat (2) @(posedge sys_clk_i) #DLY;
        note(rx_buf !== 8'h00, "buffer kept");
        note(rx_st !== 3'h0, "status kept");
        pwr = 1'b1;
        set_cfg(3'h4);
        asts_peer_i.glitch(3);
        repeat (80) @(posedge sys_clk_i);
        note(tq.size() != 0 || rq.size() != 0, "results missing");
        $display("power and start tests done");
        test_done();
    end
endmodule
